// *** shared/bcfg_pkg.sv ***
/*
 * Constants for the bridge type-1 configuration header slice (0Ch..1Fh).
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
 */
package bcfg_pkg;
    // Byte addresses
    localparam logic [7:0] OFF_DW0C = 8'h0c;
    localparam logic [7:0] OFF_DW10 = 8'h10;
    localparam logic [7:0] OFF_DW14 = 8'h14;
    localparam logic [7:0] OFF_DW18 = 8'h18;
    localparam logic [7:0] OFF_DW1C = 8'h1c;
    // Field values
    localparam logic [7:0] LAT_RST_PCI  = 8'h00;
    localparam logic [7:0] LAT_RST_PCIX = 8'h40;
    localparam logic [6:0] HDR_LAYOUT   = 7'h01;
    localparam logic [1:0] IO_ADDR32    = 2'h1;
    localparam logic [7:0] BUS_RST      = 8'h00;
    localparam logic [3:0] IO_WIN_RST   = 4'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bcfg_pkg

// *** rtl/bcfg_header.sv ***
/*
 * Bridge type-1 configuration header slice behind an AXI4-Lite slave.
 * Reset values and writability follow the straps captured just after reset.
 * Assumes orientation and bus-mode straps are stable around reset release.
 */
`timescale 1ns/1ns
`default_nettype none
module bcfg_header (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // Straps: 1 = reverse orientation, 1 = PCI-X mode (secondary side in forward, primary side in reverse)
    input  wire logic        reverse_in,
    input  wire logic        pcix_in,
    // AXI4-Lite write address / data / response
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output var  logic        s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output var  logic        s_axi_wready_out,
    output var  logic [1:0]  s_axi_bresp_out,
    output var  logic        s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read address / data
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output var  logic        s_axi_arready_out,
    output var  logic [31:0] s_axi_rdata_out,
    output var  logic [1:0]  s_axi_rresp_out,
    output var  logic        s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Status view
    output var  logic        reverse_out,
    output var  logic        pcix_out
);
    typedef struct packed {
        logic       init;
        logic       rev;
        logic       pcix;
        logic [7:0] pri_lat;
        logic [7:0] sec_lat;
        logic [7:0] pri_bus;
        logic [7:0] sec_bus;
        logic [7:0] sub_bus;
        logic [3:0] io_base;
        logic [3:0] io_limit;
        logic       aw_held;
        logic [7:0] aw_addr;
        logic       w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic       aw_rdy;
        logic       w_rdy;
        logic       ar_rdy;
    } bcfg_state_type;

    bcfg_state_type st_r;
    bcfg_state_type st_nxt;

    // Read view of a dword; reserved and absent bits are zero
    function automatic logic [31:0] rd_word(input bcfg_state_type s, input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            bcfg_pkg::OFF_DW0C: v = {8'h00, 1'b0, bcfg_pkg::HDR_LAYOUT, s.pri_lat, 8'h00};
            bcfg_pkg::OFF_DW18: v = {s.sec_lat, s.sub_bus, s.sec_bus, s.pri_bus};
            // Upper status half lies outside this block and reads zero
            bcfg_pkg::OFF_DW1C: v = {8'h00, ~s.rev & ~s.pcix, 1'b0, ~s.rev, 5'h00,
                                     s.io_limit, 2'h0, bcfg_pkg::IO_ADDR32,
                                     s.io_base, 2'h0, bcfg_pkg::IO_ADDR32};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : rd_word

    // Known addresses: the slice plus the reserved dwords
    function automatic logic mapped(input logic [7:0] a);
        return (a == bcfg_pkg::OFF_DW0C) || (a == bcfg_pkg::OFF_DW10) ||
               (a == bcfg_pkg::OFF_DW14) || (a == bcfg_pkg::OFF_DW18) ||
               (a == bcfg_pkg::OFF_DW1C);
    endfunction : mapped

    // Next-state logic
    always_comb
    begin
        logic        aw_take;
        logic        w_take;
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        st_nxt  = st_r;
        // A channel is taken only while its slot is empty and straps are captured
        aw_take = s_axi_awvalid_in && !st_r.aw_held && st_r.init;
        w_take  = s_axi_wvalid_in && !st_r.w_held && st_r.init;
        wa      = st_r.aw_held ? st_r.aw_addr : s_axi_awaddr_in;
        wd      = st_r.w_held ? st_r.w_data : s_axi_wdata_in;
        ws      = st_r.w_held ? st_r.w_strb : s_axi_wstrb_in;
        // Catch straps on the first edge after reset release
        if (!st_r.init)
        begin
            st_nxt.init    = 1'b1;
            st_nxt.rev     = reverse_in;
            st_nxt.pcix    = pcix_in;
            st_nxt.pri_lat = (reverse_in && pcix_in) ? bcfg_pkg::LAT_RST_PCIX : bcfg_pkg::LAT_RST_PCI;
            st_nxt.sec_lat = (!reverse_in && pcix_in) ? bcfg_pkg::LAT_RST_PCIX : bcfg_pkg::LAT_RST_PCI;
        end
        if (aw_take)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = {s_axi_awaddr_in[7:2], 2'b00};
            wa             = {s_axi_awaddr_in[7:2], 2'b00};
        end
        if (w_take)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata_in;
            st_nxt.w_strb = s_axi_wstrb_in;
        end
        // Perform write once both halves are present and response slot free
        // A pending response blocks the commit so bresp is never overwritten
        if ((st_r.aw_held || aw_take) && (st_r.w_held || w_take) && !st_r.bvalid)
        begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = mapped(wa) ? bcfg_pkg::RESP_OKAY : bcfg_pkg::RESP_SLVERR;
            if (wa == bcfg_pkg::OFF_DW0C && ws[1] && st_r.rev)
                st_nxt.pri_lat = wd[15:8];
            if (wa == bcfg_pkg::OFF_DW18)
            begin
                if (ws[0])
                    st_nxt.pri_bus = wd[7:0];
                if (ws[1])
                    st_nxt.sec_bus = wd[15:8];
                if (ws[2])
                    st_nxt.sub_bus = wd[23:16];
                if (ws[3] && !st_r.rev)
                    st_nxt.sec_lat = wd[31:24];
            end
            if (wa == bcfg_pkg::OFF_DW1C)
            begin
                if (ws[0])
                    st_nxt.io_base = wd[7:4];
                if (ws[1])
                    st_nxt.io_limit = wd[15:12];
            end
        end
        if (st_r.bvalid && s_axi_bready_in)
            st_nxt.bvalid = 1'b0;
        // Read: accept address when no data waits, answer next cycle
        if (st_r.rvalid && s_axi_rready_in)
            st_nxt.rvalid = 1'b0;
        // The answer is built from the state at the address edge
        if (s_axi_arvalid_in && !st_r.rvalid && st_r.init)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_word(st_r, {s_axi_araddr_in[7:2], 2'b00});
            st_nxt.rresp  = mapped({s_axi_araddr_in[7:2], 2'b00}) ? bcfg_pkg::RESP_OKAY : bcfg_pkg::RESP_SLVERR;
        end
        // Readies come from flops; each drops while its slot is occupied
        st_nxt.aw_rdy = st_nxt.init && !st_nxt.aw_held;
        st_nxt.w_rdy  = st_nxt.init && !st_nxt.w_held;
        st_nxt.ar_rdy = st_nxt.init && !st_nxt.rvalid;
    end

    // State register; reset gives constants only
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_r          <= '0;
            st_r.pri_bus  <= bcfg_pkg::BUS_RST;
            st_r.io_base  <= bcfg_pkg::IO_WIN_RST;
            st_r.io_limit <= bcfg_pkg::IO_WIN_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    always_comb
    begin
        s_axi_awready_out = st_r.aw_rdy;
        s_axi_wready_out  = st_r.w_rdy;
        s_axi_bvalid_out  = st_r.bvalid;
        s_axi_bresp_out   = st_r.bresp;
        s_axi_arready_out = st_r.ar_rdy;
        s_axi_rvalid_out  = st_r.rvalid;
        s_axi_rdata_out   = st_r.rdata;
        s_axi_rresp_out   = st_r.rresp;
        reverse_out       = st_r.rev;
        pcix_out          = st_r.pcix;
    end

    // Checks: reset values; latencies chosen by the captured straps, bus numbers and io window cleared
    latency_rst_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !st_r.init ##1 st_r.init |->
        st_r.pri_lat == (($past(reverse_in) && $past(pcix_in)) ? bcfg_pkg::LAT_RST_PCIX : bcfg_pkg::LAT_RST_PCI))
        else $error("primary latency reset wrong");
    sec_lat_rst_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !st_r.init ##1 st_r.init |->
        st_r.sec_lat == ((!$past(reverse_in) && $past(pcix_in)) ? bcfg_pkg::LAT_RST_PCIX : bcfg_pkg::LAT_RST_PCI))
        else $error("secondary latency reset wrong");
    win_rst_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !st_r.init ##1 st_r.init |->
        st_r.pri_bus == bcfg_pkg::BUS_RST && st_r.sec_bus == bcfg_pkg::BUS_RST && st_r.sub_bus == bcfg_pkg::BUS_RST &&
        st_r.io_base == bcfg_pkg::IO_WIN_RST && st_r.io_limit == bcfg_pkg::IO_WIN_RST)
        else $error("bus numbers or io window not cleared by reset");

    // Read-only sides and straps never move once captured
    pri_lat_ro_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        st_r.init && !st_r.rev |=>
        $stable(st_r.pri_lat))
        else $error("primary latency changed in forward");
    sec_lat_ro_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        st_r.init && st_r.rev |=>
        $stable(st_r.sec_lat))
        else $error("secondary latency changed in reverse");
    straps_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        st_r.init |=>
        $stable(st_r.rev) && $stable(st_r.pcix))
        else $error("straps changed after capture");

    // Read answers carry the fixed fields
    hdr_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:2] == bcfg_pkg::OFF_DW0C[7:2] |=>
        s_axi_rdata_out[31:16] == {8'h00, 1'b0, bcfg_pkg::HDR_LAYOUT})
        else $error("header type read wrong");
    io_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:2] == bcfg_pkg::OFF_DW1C[7:2] |=>
        s_axi_rdata_out[3:0] == {2'h0, bcfg_pkg::IO_ADDR32} && s_axi_rdata_out[11:8] == {2'h0, bcfg_pkg::IO_ADDR32} &&
        s_axi_rdata_out[22] == 1'b0 && s_axi_rdata_out[20:16] == 5'h00 && s_axi_rdata_out[31:24] == 8'h00)
        else $error("io window fixed bits wrong");
    status_cap_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[7:2] == bcfg_pkg::OFF_DW1C[7:2] |=>
        s_axi_rdata_out[21] == !st_r.rev &&
        s_axi_rdata_out[23] == (!st_r.rev && !st_r.pcix))
        else $error("secondary status capability wrong");
    rsvd_read_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_arvalid_in && s_axi_arready_out &&
        (s_axi_araddr_in[7:2] == bcfg_pkg::OFF_DW10[7:2] || s_axi_araddr_in[7:2] == bcfg_pkg::OFF_DW14[7:2]) |=>
        s_axi_rdata_out == 32'h0000_0000 && s_axi_rresp_out == bcfg_pkg::RESP_OKAY)
        else $error("reserved dword not read as zero");
    rd_answer_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_arvalid_in && s_axi_arready_out |=>
        s_axi_rvalid_out)
        else $error("read not answered");

    // Writes land in writable fields only; misses are refused
    bus_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out &&
        s_axi_awaddr_in[7:2] == bcfg_pkg::OFF_DW18[7:2] && s_axi_wstrb_in == 4'hf |=>
        st_r.pri_bus == $past(s_axi_wdata_in[7:0]) && st_r.sec_bus == $past(s_axi_wdata_in[15:8]) &&
        st_r.sub_bus == $past(s_axi_wdata_in[23:16]))
        else $error("bus number write lost");
    io_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out &&
        s_axi_awaddr_in[7:2] == bcfg_pkg::OFF_DW1C[7:2] && s_axi_wstrb_in[1:0] == 2'h3 |=>
        st_r.io_base == $past(s_axi_wdata_in[7:4]) &&
        st_r.io_limit == $past(s_axi_wdata_in[15:12]))
        else $error("io window write lost");
    unmapped_wr_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out &&
        !mapped({s_axi_awaddr_in[7:2], 2'h0}) |=>
        s_axi_bvalid_out && s_axi_bresp_out == bcfg_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    wr_answer_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && !s_axi_bvalid_out |=>
        s_axi_bvalid_out)
        else $error("write not answered");

    // Main scenarios
    wr_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_bvalid_out && s_axi_bready_in);
    rd_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_rvalid_out && s_axi_rready_in);
    rev_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        st_r.init && st_r.rev && st_r.pcix);
    fwd_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        st_r.init && !st_r.rev && st_r.pcix);
    slverr_cov_c: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        s_axi_bvalid_out && s_axi_bready_in && s_axi_bresp_out == bcfg_pkg::RESP_SLVERR);
endmodule : bcfg_header
`default_nettype wire

// *** tb/bcfg_header_tb.sv ***
/*
 * Self-checking bench for the bridge header register slice, all four strap settings.
 * Assumes the design answers on AXI4-Lite with registered outputs and latches its straps at reset.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp); \
        end \
    end
module bcfg_header_tb;
    // Design inputs
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        reverse_in = 1'b0;
    logic        pcix_in = 1'b0;
    logic [7:0]  s_axi_awaddr_in = 8'h00;
    logic [7:0]  s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h00000000;
    logic [3:0]  s_axi_wstrb_in = 4'h0;
    logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    // Design outputs
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out;
    logic        reverse_out, pcix_out;
    // Bookkeeping
    int          errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [31:0] rd_data;
    logic [1:0]  resp;

    bcfg_header u_bcfg_header (
        .clk_in, .reset_n_in, .reverse_in, .pcix_in,
        .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
        .reverse_out, .pcix_out
    );

    // 125 MHz clock
    always #4 clk_in = ~clk_in;

    // Cuts a hung run short
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            final_report();
        end
    end

    // Expected latency bytes and low status half for a strap setting
    function automatic logic [7:0] lat_p(input logic rev, input logic px);
        return (rev && px) ? bcfg_pkg::LAT_RST_PCIX : bcfg_pkg::LAT_RST_PCI;
    endfunction : lat_p
    function automatic logic [7:0] lat_s(input logic rev, input logic px);
        return (!rev && px) ? bcfg_pkg::LAT_RST_PCIX : bcfg_pkg::LAT_RST_PCI;
    endfunction : lat_s
    function automatic logic [23:0] st_lo(input logic rev, input logic px, input logic [3:0] n);
        return {!rev && !px, 1'b0, !rev, 5'h00, n, 2'h0, bcfg_pkg::IO_ADDR32, n, 2'h0, bcfg_pkg::IO_ADDR32};
    endfunction : st_lo

    // Strap setting, reset held 20 cycles, first request from the second edge
    task automatic do_reset(input logic rev, input logic px);
        reverse_in <= rev;
        pcix_in    <= px;
        reset_n_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask : do_reset

    // One write; each channel held until taken, then one idle edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr_in  <= a;
        s_axi_wdata_in   <= d;
        s_axi_wstrb_in   <= s;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in  <= 1'b1;
        s_axi_bready_in  <= 1'b1;
        @(posedge clk_in);
        while (s_axi_bvalid_out !== 1'b1)
        begin
            if (s_axi_awready_out === 1'b1)
                s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out === 1'b1)
                s_axi_wvalid_in <= 1'b0;
            @(posedge clk_in);
        end
        resp = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
        @(posedge clk_in);
    endtask : axi_wr

    // One read; address held until taken, data taken with rvalid
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr_in  <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in  <= 1'b1;
        @(posedge clk_in);
        while (s_axi_rvalid_out !== 1'b1)
        begin
            if (s_axi_arready_out === 1'b1)
                s_axi_arvalid_in <= 1'b0;
            @(posedge clk_in);
        end
        rd_data = s_axi_rdata_out;
        resp    = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
        @(posedge clk_in);
    endtask : axi_rd

    // Reset values and captured straps
    task automatic t_reset(input logic rev, input logic px);
        do_reset(rev, px);
        `CHK({reverse_out, pcix_out}, {rev, px}, "straps")
        axi_rd(bcfg_pkg::OFF_DW0C);
        `CHK(rd_data, {8'h00, 1'b0, bcfg_pkg::HDR_LAYOUT, lat_p(rev, px), 8'h00}, "dw0c reset")
        axi_rd(bcfg_pkg::OFF_DW18);
        `CHK(rd_data, {lat_s(rev, px), 24'h000000}, "dw18 reset")
        axi_rd(bcfg_pkg::OFF_DW1C);
        `CHK(rd_data, {8'h00, st_lo(rev, px, 4'h0)}, "dw1c reset")
        $display("test reset rev=%0b pcix=%0b done", rev, px);
    endtask : t_reset

    // All-ones writes after the straps flip; only writable bits follow
    task automatic t_write(input logic rev, input logic px);
        logic [7:0] adr [4] = '{bcfg_pkg::OFF_DW0C, bcfg_pkg::OFF_DW18, bcfg_pkg::OFF_DW1C, bcfg_pkg::OFF_DW10};
        reverse_in <= ~rev;
        pcix_in    <= ~px;
        foreach (adr[i])
        begin
            axi_wr(adr[i], 32'hffffffff, 4'hf);
            `CHK(resp, bcfg_pkg::RESP_OKAY, "write resp")
        end
        axi_rd(bcfg_pkg::OFF_DW0C);
        `CHK(rd_data, {8'h00, 1'b0, bcfg_pkg::HDR_LAYOUT, rev ? 8'hff : lat_p(rev, px), 8'h00}, "dw0c")
        axi_rd(bcfg_pkg::OFF_DW18);
        `CHK(rd_data, {rev ? lat_s(rev, px) : 8'hff, 24'hffffff}, "dw18")
        axi_rd(bcfg_pkg::OFF_DW1C);
        `CHK(rd_data, {8'h00, st_lo(rev, px, 4'hf)}, "dw1c")
        axi_rd(bcfg_pkg::OFF_DW10);
        `CHK({resp, rd_data}, {bcfg_pkg::RESP_OKAY, 32'h00000000}, "dw10")
        $display("test write rev=%0b pcix=%0b done", rev, px);
    endtask : t_write

    // Byte strobe lets only the low bus number change
    task automatic t_strobe();
        axi_wr(bcfg_pkg::OFF_DW18, 32'h12345678, 4'h1);
        axi_rd(bcfg_pkg::OFF_DW18);
        `CHK(rd_data[23:0], 24'hffff78, "strobe")
        $display("test strobe done");
    endtask : t_strobe

    // Address outside the slice is refused and reads zero
    task automatic t_unmapped();
        axi_wr(8'h20, 32'hffffffff, 4'hf);
        `CHK(resp, bcfg_pkg::RESP_SLVERR, "unmapped write")
        axi_rd(8'h20);
        `CHK({resp, rd_data}, {bcfg_pkg::RESP_SLVERR, 32'h00000000}, "unmapped read")
        $display("test unmapped done");
    endtask : t_unmapped

    // Prints the counts and the verdict, then ends the run
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // Main sequence over every strap setting
    initial
    begin
        for (int m = 0; m < 4; m++)
        begin
            t_reset(m[1], m[0]);
            t_write(m[1], m[0]);
            t_strobe();
        end
        t_unmapped();
        final_report();
    end
endmodule : bcfg_header_tb
`default_nettype wire
